// file: design/ringmt_pkg.sv
// Purpose: Shared constants of the ring MAC timer and counter block.
// Assumes: 16-bit node processor register bus with a 7-bit address.
// Notes: Timer widths and reset values are kept here once.
package ringmt_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Register addresses on the node processor bus.
    localparam logic [6:0] ADDR_ASYNC_QUEUE0_THRESHOLD = 7'h10;
    localparam logic [6:0] ADDR_ASYNC_QUEUE1_THRESHOLD = 7'h11;
    localparam logic [6:0] ADDR_ASYNC_QUEUE2_THRESHOLD = 7'h12;
    localparam logic [6:0] ADDR_DEF_ROT = 7'h13;
    localparam logic [6:0] ADDR_TVX = 7'h14;
    localparam logic [6:0] ADDR_REQ_HIGH = 7'h15;
    localparam logic [6:0] ADDR_REQ_LOW = 7'h16;
    localparam logic [6:0] ADDR_ROT_UPPER = 7'h17;
    localparam logic [6:0] ADDR_HOLD_UPPER = 7'h18;
    localparam logic [6:0] ADDR_NEG_UPPER = 7'h19;
    localparam logic [6:0] ADDR_SYNC_BW = 7'h1a;
    localparam logic [6:0] ADDR_FRAME_CNT = 7'h1b;
    localparam logic [6:0] ADDR_ERR_CNT = 7'h1c;
    localparam logic [6:0] ADDR_LOST_CNT = 7'h1d;
    localparam logic [6:0] ADDR_SNAPSHOT = 7'h1e;
    ////////////////////////////////////////////////////////////////////////
    // Timer geometry.
    localparam int TMR_W = 21;
    localparam int LOW_W = 5;
    localparam logic [20:0] TMR_EXPIRED = 21'h1fffff;
    localparam logic [4:0] LOW_ZERO = 5'h00;
    localparam logic [7:0] TVX_EXPIRED = 8'hff;
    localparam logic [7:0] TVX_PRESCALE = 8'hff;
    ////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [15:0] PRI_RST = 16'hffff;
    localparam logic [15:0] DEF_ROT_RST = 16'h0000;
    localparam logic [7:0] TVX_REG_RST = 8'h00;
    localparam logic [7:0] TVX_TMR_RST = 8'hff;
    localparam logic [15:0] REQ_RST = 16'h0000;
    localparam logic [20:0] ROT_RST = 21'h00000;
    localparam logic [20:0] HOLD_RST = 21'h00fff;
    localparam logic [20:0] NEG_RST = 21'h00000;
    localparam logic [15:0] SYNC_BW_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    ////////////////////////////////////////////////////////////////////////
    // Bit positions in the lower status-2 word.
    localparam int ST_FRAME_OVF = 4;
    localparam int ST_ERR_OVF = 5;
    localparam int ST_LOST_OVF = 6;
    localparam int ST_ROT_EXP = 10;
    localparam int ST_TVX_EXP = 11;
endpackage

// file: design/ringmt_evt_counter.sv
// Purpose: Presettable event counter with overflow pulse.
// Assumes: Load and count come from logic on the same clock.
// Notes: A load wins over a count in the same cycle.
`timescale 1ns/100ps
module ringmt_evt_counter #(
    parameter int W = 16,
    parameter logic [W-1:0] RST_VALUE = '0
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst,
    // Preset and count.
    input wire logic i_load,
    input wire logic [W-1:0] i_load_value,
    input wire logic i_inc,
    // Results.
    output logic [W-1:0] o_count,
    output logic o_overflow
);
    // Counting wraps to zero so no event after an overflow is dropped.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_count <= RST_VALUE;
        end else if (i_load) begin
            o_count <= i_load_value;
        end else if (i_inc) begin
            o_count <= o_count + 1'b1;
        end
    end

    // The overflow pulse marks the wrap from all ones to zero.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_overflow <= 1'b0;
        end else begin
            o_overflow <= i_inc && !i_load && (&o_count);
        end
    end
endmodule // ringmt_evt_counter

// file: design/ringmt_prescaler.sv
// Purpose: Divides the clock to a one-cycle tick.
// Assumes: i_clear restarts the division phase.
// Notes: One tick every DIV clocks.
`timescale 1ns/100ps
module ringmt_prescaler #(
    parameter int W = 8,
    parameter logic [W-1:0] DIV = 8'hff
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst,
    // Phase control and tick.
    input wire logic i_clear,
    output logic o_tick
);
    logic [W-1:0] count;

    // Clearing keeps the slow timer's first step a full period after reload.
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_clear) begin
            count <= '0;
            o_tick <= 1'b0;
        end else if (count == DIV - 1'b1) begin
            count <= '0;
            o_tick <= 1'b1;
        end else begin
            count <= count + 1'b1;
            o_tick <= 1'b0;
        end
    end
endmodule // ringmt_prescaler

// file: design/ringmt_timers.sv
// Purpose: Timers, counters and async thresholds of a token ring MAC.
// Assumes: All event inputs come from MAC logic on i_mclk.
// Notes: Registers are read and written over the node processor bus.
// Notes on behaviour
// - Async queues served in order 0, 1, 2.
// - Async sends need token, enable, threshold exceeded.
// - Thresholds rechecked per frame; release when done.
// - Nontag needs enable command; tag mode does not.
// - Default rotation loads timer upper bits on init.
// - Claim uses default rotation as operational time.
// - Valid-transmission expiry starts ring recovery.
// - 8-bit valid timer steps at clock/255.
// - Valid read: timer high byte, register low.
// - Diagnostic command copies register into valid timer.
// - Requested rotation is 32 bits, two words.
// - Rotation expiry with late count enters claim.
// - Rotation expiry, zero late: count, reload negotiated.
// - Timer upper bits readable, writable; low via snapshot.
// - Token capture, zero late: holding takes rotation.
// - Negotiated time keeps low 21 bits only.
// - Bandwidth write sets upper bits of sync timer; code loads sync_bw there at i_sync_start.
// - Sync frame needs queue, no done, timer unexpired.
// - Frame counter counts, presets, overflows to bit 4.
// - Error counter counts new errors, overflow bit 5.
// - Lost counter counts lost frames, overflow bit 6.
// - Snapshot holds late, negotiated, rotation, holding lows.
// - 21-bit timers expire at all ones.
// - Valid timer expiry sets status bit 11.
// - Claim-causing rotation expiry sets status bit 10.
`timescale 1ns/100ps
module ringmt_timers (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst,
    // Node processor bus.
    input wire logic [6:0] i_np_addr,
    input wire logic i_np_wr,
    input wire logic i_np_rd,
    input wire logic [15:0] i_np_wdata,
    output logic [15:0] o_np_rdata,
    // Ring state events.
    input wire logic i_init_load,
    input wire logic i_claim_active,
    input wire logic i_claim_done,
    input wire logic [20:0] i_claim_neg,
    input wire logic i_valid_frame_end,
    input wire logic i_token_captured,
    input wire logic i_diag_load_tvx,
    // Receive events.
    input wire logic i_frame_rcvd,
    input wire logic i_err_frame_new,
    input wire logic i_frame_lost,
    // Synchronous queue.
    input wire logic i_sync_start,
    input wire logic i_sync_queued,
    input wire logic i_desc_done,
    // Asynchronous queues.
    input wire logic i_tag_mode,
    input wire logic [2:0] i_async_cmd_en,
    input wire logic [2:0] i_async_empty,
    input wire logic i_async_phase,
    input wire logic i_frame_done,
    // Results to the MAC.
    output logic [2:0] o_async_grant,
    output logic o_token_release,
    output logic o_sync_send_ok,
    output logic o_claim_enter,
    output logic o_ring_recover,
    output logic o_late,
    output logic [20:0] o_oper_rotation,
    output logic [31:0] o_requested_rotation,
    output logic [15:0] o_status_set
);
    ////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [15:0] pri [3];
    logic [15:0] def_rot;
    logic [7:0] tvx_reg;
    logic [7:0] tvx_tmr;
    logic [15:0] req_high;
    logic [15:0] req_low;
    logic [20:0] rot_tmr;
    logic [20:0] hold_tmr;
    logic [20:0] neg_time;
    logic [15:0] sync_bw;
    logic [20:0] sync_tmr;
    logic [2:0] cmd_en;
    logic phase_q;
    logic tvx_tick;
    logic [15:0] frame_cnt;
    logic [15:0] err_cnt;
    logic [15:0] lost_cnt;
    logic frame_ovf;
    logic err_ovf;
    logic lost_ovf;
    logic [2:0] next_grant;
    logic eval_point;
    logic rot_expired;
    logic tvx_expire;
    logic [15:0] next_status;

    // Write strobes, one per address.
    function automatic logic wr_to(input logic [6:0] a);
        return i_np_wr && (i_np_addr == a);
    endfunction

    // The holding timer must strictly exceed the queue threshold.
    function automatic logic above(input logic [20:0] t, input logic [15:0] p);
        return t[20:5] > p;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Programmable registers.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pri[0] <= ringmt_pkg::PRI_RST;
            pri[1] <= ringmt_pkg::PRI_RST;
            pri[2] <= ringmt_pkg::PRI_RST;
            def_rot <= ringmt_pkg::DEF_ROT_RST;
            tvx_reg <= ringmt_pkg::TVX_REG_RST;
            req_high <= ringmt_pkg::REQ_RST;
            req_low <= ringmt_pkg::REQ_RST;
            sync_bw <= ringmt_pkg::SYNC_BW_RST;
        end else begin
            if (wr_to(ringmt_pkg::ADDR_ASYNC_QUEUE0_THRESHOLD)) pri[0] <= i_np_wdata;
            if (wr_to(ringmt_pkg::ADDR_ASYNC_QUEUE1_THRESHOLD)) pri[1] <= i_np_wdata;
            if (wr_to(ringmt_pkg::ADDR_ASYNC_QUEUE2_THRESHOLD)) pri[2] <= i_np_wdata;
            if (wr_to(ringmt_pkg::ADDR_DEF_ROT)) def_rot <= i_np_wdata;
            if (wr_to(ringmt_pkg::ADDR_TVX)) tvx_reg <= i_np_wdata[7:0];
            if (wr_to(ringmt_pkg::ADDR_REQ_HIGH)) req_high <= i_np_wdata;
            if (wr_to(ringmt_pkg::ADDR_REQ_LOW)) req_low <= i_np_wdata;
            if (wr_to(ringmt_pkg::ADDR_SYNC_BW)) sync_bw <= i_np_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Token rotation timer and late count.
    assign rot_expired = (rot_tmr == ringmt_pkg::TMR_EXPIRED);

    // Test writes win, then init, then token capture, then expiry.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rot_tmr <= ringmt_pkg::ROT_RST;
            o_late <= 1'b0;
            o_claim_enter <= 1'b0;
        end else begin
            o_claim_enter <= 1'b0;
            if (wr_to(ringmt_pkg::ADDR_ROT_UPPER)) begin
                rot_tmr <= {i_np_wdata, ringmt_pkg::LOW_ZERO};
            end else if (i_init_load) begin
                rot_tmr <= {def_rot, ringmt_pkg::LOW_ZERO};
                o_late <= 1'b0;
            end else if (i_token_captured) begin
                rot_tmr <= neg_time;
                o_late <= 1'b0;
            end else if (rot_expired && o_late) begin
                o_claim_enter <= 1'b1;
                rot_tmr <= {def_rot, ringmt_pkg::LOW_ZERO};
                o_late <= 1'b0;
            end else if (rot_expired) begin
                o_late <= 1'b1;
                rot_tmr <= neg_time;
            end else begin
                rot_tmr <= rot_tmr + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Token holding timer runs while async frames may be sent.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            hold_tmr <= ringmt_pkg::HOLD_RST;
        end else if (wr_to(ringmt_pkg::ADDR_HOLD_UPPER)) begin
            hold_tmr <= {i_np_wdata, ringmt_pkg::LOW_ZERO};
        end else if (i_token_captured && !o_late) begin
            hold_tmr <= rot_tmr;
        end else if (i_async_phase && hold_tmr != ringmt_pkg::TMR_EXPIRED) begin
            hold_tmr <= hold_tmr + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Negotiated time; upper bits beyond 21 are implied ones.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            neg_time <= ringmt_pkg::NEG_RST;
        end else if (i_claim_done) begin
            neg_time <= i_claim_neg;
        end
    end

    // During claim the default time stands in as operational time.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_oper_rotation <= ringmt_pkg::NEG_RST;
            o_requested_rotation <= {ringmt_pkg::REQ_RST, ringmt_pkg::REQ_RST};
        end else begin
            o_oper_rotation <= i_claim_active ? {def_rot, ringmt_pkg::LOW_ZERO} : neg_time;
            o_requested_rotation <= {req_high, req_low};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Valid-transmission timer, stepping once every 255 clocks.
    ringmt_prescaler #(
        .W(8),
        .DIV(ringmt_pkg::TVX_PRESCALE)
    ) u_tvx_div (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_clear(i_valid_frame_end || i_diag_load_tvx),
        .o_tick(tvx_tick)
    );

    assign tvx_expire = tvx_tick && (tvx_tmr == ringmt_pkg::TVX_EXPIRED);

    // Every valid frame end restarts the interval being measured.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            tvx_tmr <= ringmt_pkg::TVX_TMR_RST;
            o_ring_recover <= 1'b0;
        end else begin
            o_ring_recover <= tvx_expire;
            if (i_valid_frame_end || i_diag_load_tvx || tvx_expire) begin
                tvx_tmr <= tvx_reg;
            end else if (tvx_tick) begin
                tvx_tmr <= tvx_tmr + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronous transmit timer and send permission.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sync_tmr <= ringmt_pkg::TMR_EXPIRED;
            o_sync_send_ok <= 1'b0;
        end else begin
            if (i_sync_start) begin
                sync_tmr <= {sync_bw, ringmt_pkg::LOW_ZERO};
            end else if (sync_tmr != ringmt_pkg::TMR_EXPIRED) begin
                sync_tmr <= sync_tmr + 1'b1;
            end
            o_sync_send_ok <= i_sync_queued && !i_desc_done && sync_tmr != ringmt_pkg::TMR_EXPIRED;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Queue enables: commands in nontag mode, always on in tag mode.
    // A new command wins over the clear that an empty queue causes.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cmd_en <= 3'h0;
        end else begin
            for (int q = 0; q < 3; q++) begin
                if (i_async_cmd_en[q]) begin
                    cmd_en[q] <= 1'b1;
                end else if (o_async_grant[q] && i_async_empty[q]) begin
                    cmd_en[q] <= 1'b0;
                end
            end
        end
    end

    // Priority pick among eligible queues, lowest number first.
    always_comb begin
        next_grant = 3'h0;
        for (int q = 2; q >= 0; q--) begin
            if ((i_tag_mode || cmd_en[q]) && !i_async_empty[q] && above(hold_tmr, pri[q])) begin
                next_grant = 3'h0;
                next_grant[q] = 1'b1;
            end
        end
    end

    // Choice is made at phase start and after each frame, never mid-frame.
    assign eval_point = i_async_phase && (!phase_q || i_frame_done);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            phase_q <= 1'b0;
            o_async_grant <= 3'h0;
            o_token_release <= 1'b0;
        end else begin
            phase_q <= i_async_phase;
            o_token_release <= eval_point && (next_grant == 3'h0);
            if (!i_async_phase) begin
                o_async_grant <= 3'h0;
            end else if (eval_point) begin
                o_async_grant <= next_grant;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame, error and lost counters.
    ringmt_evt_counter #(
        .W(16),
        .RST_VALUE(ringmt_pkg::CNT_RST)
    ) u_frame_cnt (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_load(wr_to(ringmt_pkg::ADDR_FRAME_CNT)),
        .i_load_value(i_np_wdata),
        .i_inc(i_frame_rcvd),
        .o_count(frame_cnt),
        .o_overflow(frame_ovf)
    );

    ringmt_evt_counter #(
        .W(16),
        .RST_VALUE(ringmt_pkg::CNT_RST)
    ) u_err_cnt (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_load(wr_to(ringmt_pkg::ADDR_ERR_CNT)),
        .i_load_value(i_np_wdata),
        .i_inc(i_err_frame_new),
        .o_count(err_cnt),
        .o_overflow(err_ovf)
    );

    ringmt_evt_counter #(
        .W(16),
        .RST_VALUE(ringmt_pkg::CNT_RST)
    ) u_lost_cnt (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_load(wr_to(ringmt_pkg::ADDR_LOST_CNT)),
        .i_load_value(i_np_wdata),
        .i_inc(i_frame_lost),
        .o_count(lost_cnt),
        .o_overflow(lost_ovf)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status set pulses toward the lower status-2 word.
    always_comb begin
        next_status = 16'h0000;
        next_status[ringmt_pkg::ST_FRAME_OVF] = frame_ovf;
        next_status[ringmt_pkg::ST_ERR_OVF] = err_ovf;
        next_status[ringmt_pkg::ST_LOST_OVF] = lost_ovf;
        next_status[ringmt_pkg::ST_ROT_EXP] = o_claim_enter;
        next_status[ringmt_pkg::ST_TVX_EXP] = o_ring_recover;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_status_set <= 16'h0000;
        end else begin
            o_status_set <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data; unmapped addresses and idle cycles return zero.
    always_ff @(posedge i_mclk) begin
        if (i_rst || !i_np_rd) begin
            o_np_rdata <= 16'h0000;
        end else begin
            unique case (i_np_addr)
                ringmt_pkg::ADDR_ASYNC_QUEUE0_THRESHOLD: o_np_rdata <= pri[0];
                ringmt_pkg::ADDR_ASYNC_QUEUE1_THRESHOLD: o_np_rdata <= pri[1];
                ringmt_pkg::ADDR_ASYNC_QUEUE2_THRESHOLD: o_np_rdata <= pri[2];
                ringmt_pkg::ADDR_DEF_ROT: o_np_rdata <= def_rot;
                ringmt_pkg::ADDR_TVX: o_np_rdata <= {tvx_tmr, tvx_reg};
                ringmt_pkg::ADDR_REQ_HIGH: o_np_rdata <= req_high;
                ringmt_pkg::ADDR_REQ_LOW: o_np_rdata <= req_low;
                ringmt_pkg::ADDR_ROT_UPPER: o_np_rdata <= rot_tmr[20:5];
                ringmt_pkg::ADDR_HOLD_UPPER: o_np_rdata <= hold_tmr[20:5];
                ringmt_pkg::ADDR_NEG_UPPER: o_np_rdata <= neg_time[20:5];
                ringmt_pkg::ADDR_SYNC_BW: o_np_rdata <= sync_bw;
                ringmt_pkg::ADDR_FRAME_CNT: o_np_rdata <= frame_cnt;
                ringmt_pkg::ADDR_ERR_CNT: o_np_rdata <= err_cnt;
                ringmt_pkg::ADDR_LOST_CNT: o_np_rdata <= lost_cnt;
                ringmt_pkg::ADDR_SNAPSHOT:
                    o_np_rdata <= {o_late, neg_time[4:0], rot_tmr[4:0], hold_tmr[4:0]};
                default: o_np_rdata <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    claim_on_late_a: assert property (
        rot_expired && o_late && !i_np_wr && !i_init_load && !i_token_captured
        |=> o_claim_enter ##1 o_status_set[ringmt_pkg::ST_ROT_EXP])
        else $error("Late expiry did not enter claim.");
    reload_negotiated_a: assert property (
        rot_expired && !o_late && !i_np_wr && !i_init_load && !i_token_captured
        |=> o_late && rot_tmr == $past(neg_time) && !o_claim_enter)
        else $error("Early expiry did not reload negotiated time.");
    init_load_a: assert property (
        i_init_load && !i_np_wr |=> rot_tmr == {$past(def_rot), 5'h00} && !o_late)
        else $error("Init did not load default rotation.");
    hold_capture_a: assert property (
        i_token_captured && !o_late && !i_np_wr |=> hold_tmr == $past(rot_tmr))
        else $error("Holding timer not loaded at capture.");
    snapshot_read_a: assert property (
        i_np_rd && i_np_addr == ringmt_pkg::ADDR_SNAPSHOT
        |=> o_np_rdata == {$past(o_late), $past(neg_time[4:0]), $past(rot_tmr[4:0]), $past(hold_tmr[4:0])})
        else $error("Snapshot layout wrong.");
    tvx_read_a: assert property (
        i_np_rd && i_np_addr == ringmt_pkg::ADDR_TVX |=> o_np_rdata == {$past(tvx_tmr), $past(tvx_reg)})
        else $error("Valid timer read layout wrong.");
    tvx_expiry_a: assert property (
        tvx_expire |=> o_ring_recover && tvx_tmr == $past(tvx_reg) ##1 o_status_set[ringmt_pkg::ST_TVX_EXP])
        else $error("Valid timer expiry not reported.");
    sync_stop_a: assert property (
        sync_tmr == ringmt_pkg::TMR_EXPIRED && !i_sync_start |=> !o_sync_send_ok)
        else $error("Sync send allowed after timer expiry.");
    grant_onehot_a: assert property ($onehot0(o_async_grant))
        else $error("Async grant is not one-hot.");
    grant_order_a: assert property (
        eval_point && (i_tag_mode || cmd_en[0]) && !i_async_empty[0] && hold_tmr[20:5] > pri[0]
        |=> o_async_grant == 3'h1)
        else $error("Async grant order broken.");
    release_empty_a: assert property (
        o_token_release |-> o_async_grant == 3'h0 && $past(i_async_phase))
        else $error("Token released while a queue is granted.");

    sync_run_c: cover property (i_sync_start ##1 o_sync_send_ok [*3]);
    claim_c: cover property (o_late ##[1:1000] o_claim_enter);
    async_c: cover property (o_async_grant == 3'h2 ##[1:50] o_token_release);
endmodule // ringmt_timers

// file: tb/ringmt_np_model.sv
// Purpose: Node processor model driving the register bus.
// Assumes: Requests launch 1 ns after a rising edge.
// Notes: Write data is inverted once released so stale data never looks valid.
`timescale 1ns/100ps
module ringmt_np_model (
    // Clock.
    input wire logic i_mclk,
    // Bus outputs toward the block.
    output logic [6:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [15:0] o_wdata,
    // Read data from the block.
    input wire logic [15:0] i_rdata
);
    // One write strobe per access, held across exactly one taking edge.
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        #1 o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_mclk);
        #1 o_wr = 1'b0;
        o_wdata = ~d;
    endtask
    // Data is taken in the cycle after the read edge, since it stands one cycle.
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        #1 o_addr = a;
        o_rd = 1'b1;
        @(posedge i_mclk);
        #1 o_rd = 1'b0;
        d = i_rdata;
    endtask
endmodule // ringmt_np_model

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the ring MAC timer block.
// Assumes: 100 MHz clock, synchronous reset held 10 cycles.
// Notes: Register side, the frame counter, timers and async grants are exercised.
`timescale 1ns/100ps
module tb_top;
    logic i_mclk, i_rst, w, r, pl, ca, cd, vfe, tc, dg, fr, ef, fl, ss, sq, dd, tm, ap, fd;
    logic rel, sok, clm, rec, late;
    logic [6:0] a;
    logic [15:0] wd, rdat, st, v;
    logic [20:0] cn, opr;
    logic [2:0] ce, ae, gr;
    logic [31:0] rqr;
    int err_total, checks_done, cyc;
    ringmt_np_model np (.i_mclk(i_mclk), .o_addr(a), .o_wr(w), .o_rd(r), .o_wdata(wd), .i_rdata(rdat));
    ringmt_timers dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_np_addr(a), .i_np_wr(w), .i_np_rd(r),
        .i_np_wdata(wd), .o_np_rdata(rdat), .i_init_load(pl), .i_claim_active(ca), .i_claim_done(cd),
        .i_claim_neg(cn), .i_valid_frame_end(vfe), .i_token_captured(tc), .i_diag_load_tvx(dg),
        .i_frame_rcvd(fr), .i_err_frame_new(ef), .i_frame_lost(fl), .i_sync_start(ss),
        .i_sync_queued(sq), .i_desc_done(dd), .i_tag_mode(tm), .i_async_cmd_en(ce),
        .i_async_empty(ae), .i_async_phase(ap), .i_frame_done(fd), .o_async_grant(gr),
        .o_token_release(rel), .o_sync_send_ok(sok), .o_claim_enter(clm), .o_ring_recover(rec),
        .o_late(late), .o_oper_rotation(opr), .o_requested_rotation(rqr), .o_status_set(st));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Reset values, split valid read and an unmapped address.
    task automatic t_reset();
        np.rd(7'h10, v); chk("thr0", 32'hffff, v);
        np.rd(7'h14, v); chk("valid", 32'hff00, v);
        np.rd(7'h18, v); chk("hold", 32'h007f, v);
        np.rd(7'h7f, v); chk("unmapped", 32'h0, v);
    endtask
    // Preset at the top of the count, then wrap with overflow status.
    task automatic t_wrap();
        np.wr(7'h1b, 16'hffff);
        @(posedge i_mclk); #1 fr = 1'b1;
        @(posedge i_mclk); #1 fr = 1'b0;
        v = '0;
        repeat (4) begin
            @(posedge i_mclk); #1 v |= st;
        end
        chk("frm_ovf", 32'h10, {16'h0, v});
        np.rd(7'h1b, v); chk("frm_cnt", 32'h0, v);
    endtask
    // Two words form the requested rotation; diagnostic load copies valid register.
    task automatic t_words();
        np.wr(7'h15, 16'h1234);
        np.wr(7'h16, 16'habcd);
        repeat (2) @(posedge i_mclk);
        #1 chk("req", 32'h1234abcd, rqr);
        np.wr(7'h14, 16'h00fe);
        @(posedge i_mclk); #1 dg = 1'b1;
        @(posedge i_mclk); #1 dg = 1'b0;
        np.rd(7'h14, v); chk("valid_diag", 32'hfefe, v);
        v = '0;
        repeat (600) begin
            @(posedge i_mclk); #1 v |= st;
            v[0] |= rec;
        end
        chk("valid_expiry", 32'h0801, {16'h0, v});
    endtask
    // Tag mode grants in queue order; nontag mode waits for an enable command.
    task automatic t_async();
        np.wr(7'h11, 16'h0010);
        @(posedge i_mclk); #1 tm = 1'b1;
        ap = 1'b1;
        @(posedge i_mclk); #1 chk("grant_q1", 32'h2, gr);
        np.wr(7'h10, 16'h0010);
        @(posedge i_mclk); #1 fd = 1'b1;
        @(posedge i_mclk); #1 fd = 1'b0;
        chk("grant_q0", 32'h1, gr);
        @(posedge i_mclk); #1 tm = 1'b0;
        fd = 1'b1;
        @(posedge i_mclk); #1 fd = 1'b0;
        chk("release", 32'h1, rel);
        ce = 3'h2;
        @(posedge i_mclk); #1 ce = 3'h0;
        fd = 1'b1;
        @(posedge i_mclk); #1 fd = 1'b0;
        chk("cmd_grant", 32'h2, gr);
        ap = 1'b0;
    endtask
    // A near-expiry bandwidth setting allows sends only until the timer runs out.
    task automatic t_sync();
        np.wr(7'h1a, 16'hffff);
        @(posedge i_mclk); #1 sq = 1'b1;
        ss = 1'b1;
        @(posedge i_mclk); #1 ss = 1'b0;
        @(posedge i_mclk); #1 chk("sync_ok", 32'h1, sok);
        repeat (32) @(posedge i_mclk);
        #1 chk("sync_stop", 32'h0, sok);
        sq = 1'b0;
    endtask
    // First expiry sets late, the second enters claim; then init and capture loads.
    task automatic t_rotation();
        @(posedge i_mclk); #1 cn = 21'h1ffff0;
        cd = 1'b1;
        @(posedge i_mclk); #1 cd = 1'b0;
        np.wr(7'h17, 16'hffff);
        repeat (40) @(posedge i_mclk);
        #1 chk("late", 32'h1, late);
        chk("oper", 32'h1ffff0, opr);
        v = '0;
        repeat (12) begin
            @(posedge i_mclk); #1 v |= st;
            v[0] |= clm;
        end
        chk("claim", 32'h401, {16'h0, v & 16'h0401});
        np.wr(7'h13, 16'h0123);
        @(posedge i_mclk); #1 pl = 1'b1;
        @(posedge i_mclk); #1 pl = 1'b0;
        np.rd(7'h17, v); chk("rot_init", 32'h0123, v);
        @(posedge i_mclk); #1 tc = 1'b1;
        @(posedge i_mclk); #1 tc = 1'b0;
        np.rd(7'h18, v); chk("hold_capture", 32'h0123, v);
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Hang guard well above the 760 or so cycles the tasks need.
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        {i_rst, pl, ca, cd, vfe, tc, dg, fr, ef, fl, ss, sq, dd, tm, ap, fd} = 16'h8000;
        {cn, ce, ae} = '0;
        {np.o_addr, np.o_wr, np.o_rd, np.o_wdata} = '0;
        repeat (10) @(posedge i_mclk);
        #1 i_rst = 1'b0;
        t_reset();
        t_wrap();
        t_async();
        t_sync();
        t_words();
        t_rotation();
        end_of_test();
    end
endmodule // tb_top
